// >>> design/ddr_cmd_pkg.sv
// Shared constants, command codes and decode for the DDR command link
// Notes on behaviour
// RQ1: Activate carries full row on address bus.
// RQ2: Column from low ten address lines.
// RQ3: Flag high closes bank after access.
// RQ4: Precharge flag high closes all banks.
// RQ5: Chop flag low shortens the burst.
// RQ6: Select high masks every command.
// RQ7: Row low, column and write high: activate.
// RQ8: Row low, column high, write low: precharge.
// RQ9: Row high, column low: read or write.
// RQ10: Pins latched at rising true clock.
// RQ11: Strobe pair times data both directions.
// RQ12: Bank select picks one of eight banks.
// RQ13: All strobes high is no operation.
package ddr_cmd_pkg;
	localparam int ROW_W = 14;
	localparam int COL_W = 10;
	localparam int BANK_W = 3;
	localparam int BANKS = 8;
	localparam int DQ_W = 8;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam int BEAT_W = 4;
	localparam int IDX_W = 3;
	localparam int MEM_DEPTH = 64;
	localparam int CNT_W = 8;
	localparam int PRE_CK = 4;
	localparam logic [BEAT_W-1:0] BURST_FULL = 4'h8;
	localparam logic [BEAT_W-1:0] BURST_CHOP = 4'h4;
	// Link cycles each beat is held, minus one
	localparam logic [2:0] HOLD_CK_LAST = 3'h3;
	// Controller clocks each beat is held, minus one
	localparam logic [2:0] HOLD_CLK_LAST = 3'h7;
	// Pin codes, order: select, row, column, write (all active low)
	// Deselect carries an activate code, so a leak of it would open a bank
	localparam logic [3:0] PIN_DESEL = 4'hB;
	localparam logic [3:0] PIN_NOP = 4'h7;
	localparam logic [3:0] PIN_ACT = 4'h3;
	localparam logic [3:0] PIN_PRE = 4'h2;
	localparam logic [3:0] PIN_RD = 4'h5;
	localparam logic [3:0] PIN_WR = 4'h4;

	typedef enum logic [2:0] {
		CMD_DESEL, CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_OTHER
	} cmd_type;

	typedef enum logic [1:0] {
		BANK_IDLE, BANK_ACTIVE, BANK_CLOSING
	} bank_state_type;

	// Pin levels to command
	function automatic cmd_type decode_cmd(input logic [3:0] pins);
		cmd_type c;
		c = CMD_OTHER;
		if (pins[3]) begin
			c = CMD_DESEL; // [RQ6]
		end else begin
			case (pins)
				PIN_NOP: c = CMD_NOP; // [RQ13]
				PIN_ACT: c = CMD_ACT; // [RQ7]
				PIN_PRE: c = CMD_PRE; // [RQ8]
				PIN_RD: c = CMD_RD; // [RQ9]
				PIN_WR: c = CMD_WR; // [RQ9]
				default: c = CMD_OTHER;
			endcase
		end
		return c;
	endfunction

	// Command to pin levels
	function automatic logic [3:0] encode_cmd(input cmd_type c);
		logic [3:0] p;
		p = PIN_DESEL;
		case (c)
			CMD_NOP: p = PIN_NOP;
			CMD_ACT: p = PIN_ACT;
			CMD_PRE: p = PIN_PRE;
			CMD_RD: p = PIN_RD;
			CMD_WR: p = PIN_WR;
			default: p = PIN_DESEL;
		endcase
		return p;
	endfunction
endpackage

// >>> design/ddr_link_if.sv
// Pin-level link between memory controller and DRAM command decode
`timescale 1ns/10ps
interface ddr_link_if;
	logic ck;
	logic ck_c;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [ddr_cmd_pkg::BANK_W-1:0] bank_select;
	logic [ddr_cmd_pkg::ROW_W-1:0] addr;
	// Per-end drive of the two-way data and strobe pins
	logic [ddr_cmd_pkg::DQ_W-1:0] ctl_dq_o;
	logic ctl_dqs_o;
	logic ctl_dqs_c_o;
	logic ctl_oe;
	logic [ddr_cmd_pkg::DQ_W-1:0] dev_dq_o;
	logic dev_dqs_o;
	logic dev_dqs_c_o;
	logic dev_oe;
	// Resolved wire levels; undriven reads as zero
	logic [ddr_cmd_pkg::DQ_W-1:0] dq;
	logic dqs;
	logic dqs_c;

	// Wire resolution from the enables
	assign dq = ctl_oe ? ctl_dq_o : (dev_oe ? dev_dq_o : '0);
	assign dqs = ctl_oe ? ctl_dqs_o : (dev_oe & dev_dqs_o);
	assign dqs_c = ctl_oe ? ctl_dqs_c_o : (dev_oe & dev_dqs_c_o);

	modport ctl(
		output ck, ck_c, cs_n, ras_n, cas_n, we_n, bank_select, addr,
		output ctl_dq_o, ctl_dqs_o, ctl_dqs_c_o, ctl_oe,
		input dq, dqs, dqs_c
	);
	modport dev(
		input ck, ck_c, cs_n, ras_n, cas_n, we_n, bank_select, addr,
		output dev_dq_o, dev_dqs_o, dev_dqs_c_o, dev_oe,
		input dq, dqs, dqs_c
	);
endinterface

// >>> design/ddr_device_end.sv
// DRAM-side command decode, bank state and strobe-timed data
`timescale 1ns/10ps
module ddr_device_end #(
	parameter int PRE_CK = ddr_cmd_pkg::PRE_CK
) (
	// Link, clocked by the controller's clock
	ddr_link_if.dev link,
	// User-side clock and reset
	input wire logic clk,
	input wire logic rst,
	// Decoded command events
	output logic evt_valid_q,
	output ddr_cmd_pkg::cmd_type evt_cmd_q,
	output logic [ddr_cmd_pkg::BANK_W-1:0] evt_bank_q,
	output logic [ddr_cmd_pkg::ROW_W-1:0] evt_addr_q,
	output logic evt_auto_pre_q,
	output logic evt_all_banks_q,
	output logic evt_chop_q,
	// Bank open levels
	output logic [ddr_cmd_pkg::BANKS-1:0] bank_open_q
);
	typedef enum logic [1:0] {XFER_IDLE, XFER_READ, XFER_WRITE} xfer_type;
	localparam logic [ddr_cmd_pkg::CNT_W-1:0] PRE_LOAD =
		ddr_cmd_pkg::CNT_W'(PRE_CK - 1);

	if (PRE_CK < 1 || PRE_CK > 256) begin : g_chk
		$error("PRE_CK must lie in 1..256");
	end

	logic lrst_s1_q;
	logic lrst_q;
	ddr_cmd_pkg::cmd_type cmd;
	ddr_cmd_pkg::bank_state_type bank_q [ddr_cmd_pkg::BANKS];
	ddr_cmd_pkg::bank_state_type bank_d [ddr_cmd_pkg::BANKS];
	logic [ddr_cmd_pkg::CNT_W-1:0] cnt_q [ddr_cmd_pkg::BANKS];
	logic [ddr_cmd_pkg::CNT_W-1:0] cnt_d [ddr_cmd_pkg::BANKS];
	logic [ddr_cmd_pkg::BANKS-1:0] open_q, open_d;
	xfer_type xfer_q, xfer_d;
	logic [ddr_cmd_pkg::BEAT_W-1:0] beat_q, beat_d, len_q, len_d;
	logic [2:0] hold_q, hold_d;
	logic [ddr_cmd_pkg::BANK_W-1:0] xbank_q, xbank_d;
	logic xap_q, xap_d;
	logic [ddr_cmd_pkg::DQ_W-1:0] dq_q, dq_d;
	logic dqs_q, dqs_d, dqs_c_q, dqs_c_d, oe_q, oe_d;
	logic dqs_s1_q, dqs_s2_q, dqs_s3_q;
	logic [ddr_cmd_pkg::DQ_W-1:0] dq_s1_q, dq_s2_q;
	logic [ddr_cmd_pkg::DQ_W-1:0] mem_q [ddr_cmd_pkg::MEM_DEPTH];
	logic mem_we;
	logic [ddr_cmd_pkg::BANK_W+ddr_cmd_pkg::IDX_W-1:0] mem_idx;
	logic close;
	logic etgl_q, etgl_d;
	ddr_cmd_pkg::cmd_type ecmd_q, ecmd_d;
	logic [ddr_cmd_pkg::BANK_W-1:0] ebank_q, ebank_d;
	logic [ddr_cmd_pkg::ROW_W-1:0] eaddr_q, eaddr_d;
	logic eap_q, eap_d, eall_q, eall_d, echop_q, echop_d;
	logic et_s1_q, et_s2_q, et_s3_q;
	logic [ddr_cmd_pkg::BANKS-1:0] bo_s1_q;
	logic evt_valid_d;

	// Link-domain reset: asserts at once, releases on the link clock
	always_ff @(posedge link.ck or posedge rst) begin
		if (rst) begin
			lrst_s1_q <= 1'b1;
			lrst_q <= 1'b1;
		end else begin
			lrst_s1_q <= 1'b0;
			lrst_q <= lrst_s1_q;
		end
	end

	// Decode, bank state and burst sequencing on the link clock
	always_comb begin
		// Pins are taken as they stand at the rising clock edge
		cmd = ddr_cmd_pkg::decode_cmd({link.cs_n, link.ras_n,
			link.cas_n, link.we_n}); // [RQ10]
		bank_d = bank_q;
		cnt_d = cnt_q;
		xfer_d = xfer_q;
		beat_d = beat_q;
		len_d = len_q;
		hold_d = hold_q;
		xbank_d = xbank_q;
		xap_d = xap_q;
		dq_d = dq_q;
		dqs_d = dqs_q;
		dqs_c_d = dqs_c_q;
		oe_d = oe_q;
		mem_we = 1'b0;
		mem_idx = {xbank_q, beat_q[ddr_cmd_pkg::IDX_W-1:0]};
		close = 1'b0;
		etgl_d = etgl_q;
		ecmd_d = ecmd_q;
		ebank_d = ebank_q;
		eaddr_d = eaddr_q;
		eap_d = eap_q;
		eall_d = eall_q;
		echop_d = echop_q;
		// Precharge countdown; bank goes idle when it runs out
		for (int b = 0; b < ddr_cmd_pkg::BANKS; b++) begin
			if (bank_q[b] == ddr_cmd_pkg::BANK_CLOSING) begin
				if (cnt_q[b] == '0) begin
					bank_d[b] = ddr_cmd_pkg::BANK_IDLE; // [RQ8]
				end else begin
					cnt_d[b] = cnt_q[b] - 8'h01;
				end
			end
		end
		// Burst in progress; strobe edges align with data
		unique case (xfer_q)
			XFER_IDLE: begin
			end
			XFER_READ: begin
				if (hold_q != 3'h0) begin
					hold_d = hold_q - 3'h1;
				end else if (beat_q == len_q) begin
					oe_d = 1'b0;
					xfer_d = XFER_IDLE;
					close = xap_q; // [RQ3]
				end else begin
					dq_d = mem_q[mem_idx];
					dqs_d = ~dqs_q; // [RQ11]
					dqs_c_d = dqs_q;
					beat_d = beat_q + 4'h1;
					hold_d = ddr_cmd_pkg::HOLD_CK_LAST;
				end
			end
			XFER_WRITE: begin
				// Each controller strobe edge carries one byte
				if (dqs_s2_q != dqs_s3_q) begin
					mem_we = 1'b1; // [RQ11]
					beat_d = beat_q + 4'h1;
					if (beat_d == len_q) begin
						xfer_d = XFER_IDLE;
						close = xap_q; // [RQ3]
					end
				end
			end
		endcase
		// Command effects; masked commands arrive as deselect and change nothing
		unique case (cmd)
			ddr_cmd_pkg::CMD_ACT: begin
				bank_d[link.bank_select] =
					ddr_cmd_pkg::BANK_ACTIVE; // [RQ7] [RQ12]
				etgl_d = ~etgl_q;
				eaddr_d = link.addr; // [RQ1]
			end
			ddr_cmd_pkg::CMD_PRE: begin
				for (int b = 0; b < ddr_cmd_pkg::BANKS; b++) begin
					if ((link.addr[ddr_cmd_pkg::AP_BIT] ||
						ddr_cmd_pkg::BANK_W'(b) == link.bank_select) &&
						bank_q[b] == ddr_cmd_pkg::BANK_ACTIVE) begin
						bank_d[b] = ddr_cmd_pkg::BANK_CLOSING; // [RQ4] [RQ8]
						cnt_d[b] = PRE_LOAD;
					end
				end
				etgl_d = ~etgl_q;
				eaddr_d = '0;
			end
			ddr_cmd_pkg::CMD_RD, ddr_cmd_pkg::CMD_WR: begin
				// A second access during a burst is dropped
				if (xfer_q == XFER_IDLE) begin
					xfer_d = (cmd == ddr_cmd_pkg::CMD_RD) ?
						XFER_READ : XFER_WRITE; // [RQ9]
					xbank_d = link.bank_select; // [RQ12]
					xap_d = link.addr[ddr_cmd_pkg::AP_BIT]; // [RQ2] [RQ3]
					len_d = link.addr[ddr_cmd_pkg::BC_BIT] ?
						ddr_cmd_pkg::BURST_FULL :
						ddr_cmd_pkg::BURST_CHOP; // [RQ5]
					beat_d = '0;
					hold_d = 3'h0;
					oe_d = (cmd == ddr_cmd_pkg::CMD_RD); // [RQ11]
					etgl_d = ~etgl_q;
					eaddr_d = {{(ddr_cmd_pkg::ROW_W-ddr_cmd_pkg::COL_W){1'b0}},
						link.addr[ddr_cmd_pkg::COL_W-1:0]}; // [RQ2]
				end
			end
			// No operation, deselect and unknown codes change nothing
			ddr_cmd_pkg::CMD_NOP, ddr_cmd_pkg::CMD_DESEL,
			ddr_cmd_pkg::CMD_OTHER: begin
			end // [RQ6] [RQ13]
		endcase
		if (etgl_d != etgl_q) begin
			ecmd_d = cmd;
			ebank_d = link.bank_select;
			eap_d = link.addr[ddr_cmd_pkg::AP_BIT];
			eall_d = (cmd == ddr_cmd_pkg::CMD_PRE) &&
				link.addr[ddr_cmd_pkg::AP_BIT];
			echop_d = ~link.addr[ddr_cmd_pkg::BC_BIT];
		end
		// Auto-precharge after the last beat
		if (close && bank_q[xbank_q] == ddr_cmd_pkg::BANK_ACTIVE) begin
			bank_d[xbank_q] = ddr_cmd_pkg::BANK_CLOSING; // [RQ3]
			cnt_d[xbank_q] = PRE_LOAD;
		end
		for (int b = 0; b < ddr_cmd_pkg::BANKS; b++) begin
			open_d[b] = (bank_d[b] == ddr_cmd_pkg::BANK_ACTIVE);
		end
	end

	always_ff @(posedge link.ck or posedge lrst_q) begin
		if (lrst_q) begin
			for (int b = 0; b < ddr_cmd_pkg::BANKS; b++) begin
				bank_q[b] <= ddr_cmd_pkg::BANK_IDLE;
				cnt_q[b] <= '0;
			end
			open_q <= '0;
			xfer_q <= XFER_IDLE;
			beat_q <= '0;
			len_q <= '0;
			hold_q <= 3'h0;
			xbank_q <= '0;
			xap_q <= 1'b0;
			dq_q <= '0;
			dqs_q <= 1'b0;
			dqs_c_q <= 1'b1;
			oe_q <= 1'b0;
			dqs_s1_q <= 1'b0;
			dqs_s2_q <= 1'b0;
			dqs_s3_q <= 1'b0;
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			etgl_q <= 1'b0;
			ecmd_q <= ddr_cmd_pkg::CMD_NOP;
			ebank_q <= '0;
			eaddr_q <= '0;
			eap_q <= 1'b0;
			eall_q <= 1'b0;
			echop_q <= 1'b0;
		end else begin
			bank_q <= bank_d;
			cnt_q <= cnt_d;
			open_q <= open_d;
			xfer_q <= xfer_d;
			beat_q <= beat_d;
			len_q <= len_d;
			hold_q <= hold_d;
			xbank_q <= xbank_d;
			xap_q <= xap_d;
			dq_q <= dq_d;
			dqs_q <= dqs_d;
			dqs_c_q <= dqs_c_d;
			oe_q <= oe_d;
			dqs_s1_q <= link.dqs;
			dqs_s2_q <= dqs_s1_q;
			dqs_s3_q <= dqs_s2_q;
			dq_s1_q <= link.dq;
			dq_s2_q <= dq_s1_q;
			etgl_q <= etgl_d;
			ecmd_q <= ecmd_d;
			ebank_q <= ebank_d;
			eaddr_q <= eaddr_d;
			eap_q <= eap_d;
			eall_q <= eall_d;
			echop_q <= echop_d;
		end
	end

	// Burst store; small, so no reset on the array
	always_ff @(posedge link.ck) begin
		if (mem_we) begin
			mem_q[mem_idx] <= dq_s2_q;
		end
	end

	assign link.dev_dq_o = dq_q;
	assign link.dev_dqs_o = dqs_q;
	assign link.dev_dqs_c_o = dqs_c_q;
	assign link.dev_oe = oe_q;

	// Event toggle crossing; fields are held until the next command
	assign evt_valid_d = et_s2_q ^ et_s3_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			et_s1_q <= 1'b0;
			et_s2_q <= 1'b0;
			et_s3_q <= 1'b0;
			bo_s1_q <= '0;
			bank_open_q <= '0;
			evt_valid_q <= 1'b0;
			evt_cmd_q <= ddr_cmd_pkg::CMD_NOP;
			evt_bank_q <= '0;
			evt_addr_q <= '0;
			evt_auto_pre_q <= 1'b0;
			evt_all_banks_q <= 1'b0;
			evt_chop_q <= 1'b0;
		end else begin
			et_s1_q <= etgl_q;
			et_s2_q <= et_s1_q;
			et_s3_q <= et_s2_q;
			bo_s1_q <= open_q;
			bank_open_q <= bo_s1_q;
			evt_valid_q <= evt_valid_d;
			if (evt_valid_d) begin
				evt_cmd_q <= ecmd_q;
				evt_bank_q <= ebank_q;
				evt_addr_q <= eaddr_q;
				evt_auto_pre_q <= eap_q;
				evt_all_banks_q <= eall_q;
				evt_chop_q <= echop_q;
			end
		end
	end
endmodule

// >>> design/ddr_ctrl_end.sv
// Controller end: makes the link clock, drives commands and data
`timescale 1ns/10ps
module ddr_ctrl_end (
	// Link to the DRAM
	ddr_link_if.ctl link,
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command request
	input wire logic req_valid,
	input wire ddr_cmd_pkg::cmd_type req_cmd,
	input wire logic [ddr_cmd_pkg::BANK_W-1:0] req_bank,
	input wire logic [ddr_cmd_pkg::ROW_W-1:0] req_addr,
	input wire logic req_auto_pre,
	input wire logic req_all_banks,
	input wire logic req_chop,
	input wire logic [ddr_cmd_pkg::DQ_W-1:0] req_wr_data,
	output logic req_ready_q,
	// Read data return
	output logic rd_valid_q,
	output logic [ddr_cmd_pkg::DQ_W-1:0] rd_data_q
);
	typedef enum logic [1:0] {C_IDLE, C_CMD, C_READ, C_WRITE} ctl_type;

	ctl_type state_q, state_d;
	ddr_cmd_pkg::cmd_type cmd_q, cmd_d;
	logic ck_q, ck_d, ck_c_q;
	logic [3:0] pins_q, pins_d;
	logic [ddr_cmd_pkg::BANK_W-1:0] ba_q, ba_d;
	logic [ddr_cmd_pkg::ROW_W-1:0] addr_q, addr_d;
	logic [ddr_cmd_pkg::BEAT_W-1:0] beat_q, beat_d, len_q, len_d;
	logic [2:0] hold_q, hold_d;
	logic [ddr_cmd_pkg::DQ_W-1:0] wdata_q, wdata_d, dq_q, dq_d;
	logic dqs_q, dqs_d, dqs_c_q, dqs_c_d, oe_q, oe_d;
	logic ready_d, rd_valid_d;
	logic [ddr_cmd_pkg::DQ_W-1:0] rd_data_d;
	logic r_s1_q, r_s2_q, r_s3_q;
	logic [ddr_cmd_pkg::DQ_W-1:0] rdq_s1_q, rdq_s2_q;

	// Divide-by-two link clock; commands change as it falls
	always_comb begin
		ck_d = ~ck_q;
		state_d = state_q;
		cmd_d = cmd_q;
		pins_d = pins_q;
		ba_d = ba_q;
		addr_d = addr_q;
		beat_d = beat_q;
		len_d = len_q;
		hold_d = hold_q;
		wdata_d = wdata_q;
		dq_d = dq_q;
		dqs_d = dqs_q;
		dqs_c_d = dqs_c_q;
		oe_d = oe_q;
		rd_valid_d = 1'b0;
		rd_data_d = rd_data_q;
		unique case (state_q)
			C_IDLE: begin
				// Ready only stands while the link clock is high
				if (req_valid && req_ready_q) begin
					cmd_d = req_cmd;
					pins_d = ddr_cmd_pkg::encode_cmd(req_cmd);
					ba_d = req_bank; // [RQ12]
					wdata_d = req_wr_data;
					len_d = req_chop ? ddr_cmd_pkg::BURST_CHOP :
						ddr_cmd_pkg::BURST_FULL;
					addr_d = req_addr; // [RQ1]
					if (req_cmd == ddr_cmd_pkg::CMD_RD ||
						req_cmd == ddr_cmd_pkg::CMD_WR) begin
						addr_d = '0;
						addr_d[ddr_cmd_pkg::COL_W-1:0] =
							req_addr[ddr_cmd_pkg::COL_W-1:0]; // [RQ2]
						addr_d[ddr_cmd_pkg::AP_BIT] = req_auto_pre;
						addr_d[ddr_cmd_pkg::BC_BIT] = ~req_chop;
					end else if (req_cmd == ddr_cmd_pkg::CMD_PRE) begin
						addr_d[ddr_cmd_pkg::AP_BIT] = req_all_banks;
					end
					state_d = C_CMD;
				end
			end
			C_CMD: begin
				// Pins stood stable across the rising edge just made
				if (ck_q) begin
					pins_d = ddr_cmd_pkg::PIN_NOP; // [RQ10] [RQ13]
					beat_d = '0;
					hold_d = 3'h0;
					if (cmd_q == ddr_cmd_pkg::CMD_RD) begin
						state_d = C_READ;
					end else if (cmd_q == ddr_cmd_pkg::CMD_WR) begin
						state_d = C_WRITE;
					end else begin
						state_d = C_IDLE;
					end
				end
			end
			C_WRITE: begin
				// Long beats let the DRAM resample strobe and data
				if (hold_q != 3'h0) begin
					hold_d = hold_q - 3'h1;
				end else if (beat_q == len_q) begin
					oe_d = 1'b0;
					state_d = C_IDLE;
				end else begin
					oe_d = 1'b1;
					dq_d = wdata_q + ddr_cmd_pkg::DQ_W'(beat_q);
					dqs_d = ~dqs_q; // [RQ11]
					dqs_c_d = dqs_q;
					beat_d = beat_q + 4'h1;
					hold_d = ddr_cmd_pkg::HOLD_CLK_LAST;
				end
			end
			C_READ: begin
				// No timeout: a silent DRAM stalls this end
				if (r_s2_q != r_s3_q) begin
					rd_valid_d = 1'b1; // [RQ11]
					rd_data_d = rdq_s2_q;
					beat_d = beat_q + 4'h1;
					if (beat_d == len_q) begin
						state_d = C_IDLE;
					end
				end
			end
		endcase
		ready_d = (state_d == C_IDLE) && ck_d;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= C_IDLE;
			cmd_q <= ddr_cmd_pkg::CMD_NOP;
			ck_q <= 1'b0;
			ck_c_q <= 1'b1;
			pins_q <= ddr_cmd_pkg::PIN_NOP;
			ba_q <= '0;
			addr_q <= '0;
			beat_q <= '0;
			len_q <= '0;
			hold_q <= 3'h0;
			wdata_q <= '0;
			dq_q <= '0;
			dqs_q <= 1'b0;
			dqs_c_q <= 1'b1;
			oe_q <= 1'b0;
			req_ready_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q <= '0;
			r_s1_q <= 1'b0;
			r_s2_q <= 1'b0;
			r_s3_q <= 1'b0;
			rdq_s1_q <= '0;
			rdq_s2_q <= '0;
		end else begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			ck_q <= ck_d;
			ck_c_q <= ~ck_d;
			pins_q <= pins_d;
			ba_q <= ba_d;
			addr_q <= addr_d;
			beat_q <= beat_d;
			len_q <= len_d;
			hold_q <= hold_d;
			wdata_q <= wdata_d;
			dq_q <= dq_d;
			dqs_q <= dqs_d;
			dqs_c_q <= dqs_c_d;
			oe_q <= oe_d;
			req_ready_q <= ready_d;
			rd_valid_q <= rd_valid_d;
			rd_data_q <= rd_data_d;
			r_s1_q <= link.dqs;
			r_s2_q <= r_s1_q;
			r_s3_q <= r_s2_q;
			rdq_s1_q <= link.dq;
			rdq_s2_q <= rdq_s1_q;
		end
	end

	// Pins straight from the registers
	assign link.ck = ck_q;
	assign link.ck_c = ck_c_q;
	assign link.cs_n = pins_q[3];
	assign link.ras_n = pins_q[2];
	assign link.cas_n = pins_q[1];
	assign link.we_n = pins_q[0];
	assign link.bank_select = ba_q;
	assign link.addr = addr_q;
	assign link.ctl_dq_o = dq_q;
	assign link.ctl_dqs_o = dqs_q;
	assign link.ctl_dqs_c_o = dqs_c_q;
	assign link.ctl_oe = oe_q;
endmodule

// >>> bench/ddr_link_sva.sv
// Checker for the controller-to-device command link
`timescale 1ns/10ps
module ddr_link_sva (
	// Controller clock domain
	input wire logic clk,
	input wire logic rst,
	// Link pins
	input wire logic ck,
	input wire logic ck_c,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [ddr_cmd_pkg::BANK_W-1:0] bank_select,
	input wire logic [ddr_cmd_pkg::ROW_W-1:0] addr,
	input wire logic ctl_oe,
	input wire logic dev_oe,
	input wire logic dqs,
	input wire logic dqs_c
);
	// Command code as it stands on the pins
	wire [3:0] pins = {cs_n, ras_n, cas_n, we_n};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_ck_run;
		1'b1 |=> ck != $past(ck);
	endproperty
	a_ck_run: assert property (p_ck_run)
		else $error("link clock did not toggle");

	property p_ck_pair;
		ck_c == !ck;
	endproperty
	a_ck_pair: assert property (p_ck_pair)
		else $error("link clock pair not complementary");

	property p_cmd_hold;
		(pins != ddr_cmd_pkg::PIN_NOP && $changed(pins))
			|=> $stable(pins) ##1 pins == ddr_cmd_pkg::PIN_NOP;
	endproperty
	a_cmd_hold: assert property (p_cmd_hold)
		else $error("command pins not held one link period");

	property p_addr_hold;
		(pins != ddr_cmd_pkg::PIN_NOP && $changed(pins))
			|=> $stable(addr) && $stable(bank_select);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address or bank moved during command");

	property p_one_driver;
		!(ctl_oe && dev_oe);
	endproperty
	a_one_driver: assert property (p_one_driver)
		else $error("both ends drive the data pins");

	property p_wr_dir;
		($changed(pins) && pins == ddr_cmd_pkg::PIN_WR) |-> ##[1:4] ctl_oe;
	endproperty
	a_wr_dir: assert property (p_wr_dir)
		else $error("write without controller strobe drive");

	property p_rd_dir;
		($changed(pins) && pins == ddr_cmd_pkg::PIN_RD) |-> ##[2:12] dev_oe;
	endproperty
	a_rd_dir: assert property (p_rd_dir)
		else $error("read without device strobe drive");

	property p_strobe_pair;
		(ctl_oe || dev_oe) |-> dqs_c != dqs;
	endproperty
	a_strobe_pair: assert property (p_strobe_pair)
		else $error("driven strobe pair not complementary");

	property p_beat_len;
		((ctl_oe || dev_oe) && $changed(dqs)) |=> $stable(dqs) [*7];
	endproperty
	a_beat_len: assert property (p_beat_len)
		else $error("strobe beat shorter than eight clocks");
endmodule

// >>> bench/tb.sv
// Bench: controller end and device end joined over the link
`timescale 1ns/10ps
module tb;
	logic clk;
	logic rst;
	logic req_valid;
	ddr_cmd_pkg::cmd_type req_cmd;
	logic [2:0] req_bank;
	logic [13:0] req_addr;
	logic req_auto_pre;
	logic req_all_banks;
	logic req_chop;
	logic [7:0] req_wr_data;
	logic req_ready_q;
	logic rd_valid_q;
	logic [7:0] rd_data_q;
	logic evt_valid_q;
	ddr_cmd_pkg::cmd_type evt_cmd_q;
	logic [2:0] evt_bank_q;
	logic [13:0] evt_addr_q;
	logic evt_auto_pre_q;
	logic evt_all_banks_q;
	logic evt_chop_q;
	logic [7:0] bank_open_q;
	int failures;
	int n_compared;
	int cycles;
	int open_m [8];
	logic [7:0] mem_m [64];
	logic [31:0] seed;
	logic [31:0] r;
	int b;

	ddr_link_if link();
	ddr_ctrl_end i_ddr_ctrl_end (.link(link.ctl), .clk(clk), .rst(rst),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
		.req_addr(req_addr), .req_auto_pre(req_auto_pre),
		.req_all_banks(req_all_banks), .req_chop(req_chop),
		.req_wr_data(req_wr_data), .req_ready_q(req_ready_q),
		.rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));
	// Short precharge keeps the run brief
	ddr_device_end #(.PRE_CK(1)) i_ddr_device_end (.link(link.dev),
		.clk(clk), .rst(rst), .evt_valid_q(evt_valid_q),
		.evt_cmd_q(evt_cmd_q), .evt_bank_q(evt_bank_q),
		.evt_addr_q(evt_addr_q), .evt_auto_pre_q(evt_auto_pre_q),
		.evt_all_banks_q(evt_all_banks_q), .evt_chop_q(evt_chop_q),
		.bank_open_q(bank_open_q));
	ddr_link_sva i_ddr_link_sva (.clk(clk), .rst(rst), .ck(link.ck),
		.ck_c(link.ck_c), .cs_n(link.cs_n), .ras_n(link.ras_n),
		.cas_n(link.cas_n), .we_n(link.we_n),
		.bank_select(link.bank_select), .addr(link.addr),
		.ctl_oe(link.ctl_oe), .dev_oe(link.dev_oe), .dqs(link.dqs),
		.dqs_c(link.dqs_c));

	// Xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Compare one value, count it, report a mismatch
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Counts, verdict and end of run
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One command over the link, then model update and compares
	task automatic op(input ddr_cmd_pkg::cmd_type c, input int bk,
		input logic [13:0] a, input logic flag, input logic chop,
		input logic [7:0] wd);
		logic got;
		int k;
		int i;
		int n;
		n = chop ? 4 : 8;
		@(negedge clk);
		req_valid = 1'b1;
		req_cmd = c;
		req_bank = bk[2:0];
		req_addr = a;
		req_auto_pre = flag && c != ddr_cmd_pkg::CMD_PRE;
		req_all_banks = flag && c == ddr_cmd_pkg::CMD_PRE;
		req_chop = chop;
		req_wr_data = wd;
		// Request held until an edge that sees ready high
		for (k = 0; k < 300 && req_ready_q !== 1'b1; k++)
			@(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		got = 1'b0;
		for (k = 0; k < 20 && !got; k++) begin
			@(negedge clk);
			got = evt_valid_q === 1'b1;
		end
		if (c == ddr_cmd_pkg::CMD_NOP || c == ddr_cmd_pkg::CMD_DESEL) begin
			check("event", 32'(got), 32'h0);
		end else begin
			check("event", 32'(got), 32'h1);
			check("evt_cmd", 32'(evt_cmd_q), 32'(c));
			check("evt_bank", 32'(evt_bank_q), 32'(bk));
		end
		case (c)
			ddr_cmd_pkg::CMD_ACT: begin
				check("row", 32'(evt_addr_q), 32'(a));
				open_m[bk] = 1;
			end
			ddr_cmd_pkg::CMD_PRE: begin
				check("all", 32'(evt_all_banks_q), 32'(flag));
				for (i = 0; i < 8; i++)
					if (flag || i == bk)
						open_m[i] = 0;
			end
			ddr_cmd_pkg::CMD_RD, ddr_cmd_pkg::CMD_WR: begin
				check("column", 32'(evt_addr_q), 32'(a[9:0]));
				check("auto", 32'(evt_auto_pre_q), 32'(flag));
				check("chop", 32'(evt_chop_q), 32'(chop));
				for (i = 0; i < n; i++) begin
					if (c == ddr_cmd_pkg::CMD_WR) begin
						mem_m[bk * 8 + i] = wd + 8'(i);
					end else begin
						for (k = 0; k < 60 && rd_valid_q !== 1'b1; k++)
							@(negedge clk);
						check("byte", 32'(rd_data_q), 32'(mem_m[bk * 8 + i]));
						@(negedge clk);
					end
				end
				if (flag)
					open_m[bk] = 0;
			end
			default: ;
		endcase
		// Let the burst, the close and the sync settle
		for (k = 0; k < 300 && req_ready_q !== 1'b1; k++)
			@(negedge clk);
		repeat (12) @(negedge clk);
		for (i = 0; i < 8; i++)
			check("open", 32'(bank_open_q[i]), 32'(open_m[i]));
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Hang guard: the sequence needs about a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end

	initial begin
		rst = 1'b0;
		req_valid = 1'b0;
		req_cmd = ddr_cmd_pkg::CMD_NOP;
		req_bank = 3'h0;
		req_addr = 14'h0000;
		req_auto_pre = 1'b0;
		req_all_banks = 1'b0;
		req_chop = 1'b0;
		req_wr_data = 8'h00;
		seed = 32'h0B72;
		failures = 0;
		n_compared = 0;
		cycles = 0;
		// Late rise: the link side has no clock in reset, needs a real edge
		#1 rst = 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		// Open, write, read back on random banks
		for (int t = 0; t < 4; t++) begin
			r = rnd();
			b = int'(r[2:0]);
			op(ddr_cmd_pkg::CMD_ACT, b, r[16:3], 1'b0, 1'b0, 8'h00);
			r = rnd();
			op(ddr_cmd_pkg::CMD_WR, b, {4'h4, r[9:0]}, 1'b0, 1'b0, r[17:10]);
			op(ddr_cmd_pkg::CMD_RD, b, {1'b0, !t[0], 1'b0, t[1], r[27:18]},
				t[1], t[0], 8'h00);
		end
		$display("test burst round trips done");
		// Chopped write that closes its bank
		r = rnd();
		b = int'(r[2:0]);
		op(ddr_cmd_pkg::CMD_ACT, b, r[16:3], 1'b0, 1'b0, 8'h00);
		op(ddr_cmd_pkg::CMD_WR, b, {4'h1, r[12:3]}, 1'b1, 1'b1, r[20:13]);
		$display("test chopped write done");
		// Empty and masked command cycles
		op(ddr_cmd_pkg::CMD_NOP, 0, r[13:0], 1'b0, 1'b0, 8'h00);
		op(ddr_cmd_pkg::CMD_DESEL, 2, r[13:0], 1'b0, 1'b0, 8'h00);
		$display("test idle cycles done");
		// Single bank close, then all banks close
		for (int t = 0; t < 8; t += 3)
			op(ddr_cmd_pkg::CMD_ACT, t, r[13:0] ^ 14'(t), 1'b0, 1'b0, 8'h00);
		op(ddr_cmd_pkg::CMD_PRE, 3, 14'h0000, 1'b0, 1'b0, 8'h00);
		op(ddr_cmd_pkg::CMD_PRE, 1, 14'h0400, 1'b1, 1'b0, 8'h00);
		$display("test precharge done");
		test_done();
	end
endmodule
